// >>> tpw_timer.sv
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "tpw_consts.svh"

module tpw_timer #(
  parameter int PRESCALE_BITS = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tpw_pkg::tpw_addr_t awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire tpw_pkg::tpw_word_t wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire tpw_pkg::tpw_addr_t araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output tpw_pkg::tpw_word_t rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic external_count_pin,
  input wire logic port_out_value,
  input wire logic port_dir,
  input wire logic global_irq_enable,
  input wire logic compare_irq_ack,
  input wire logic overflow_irq_ack,
  output logic wave_pin_out,
  output logic wave_pin_oe,
  output logic compare_irq_req,
  output logic overflow_irq_req
);
  import tpw_pkg::*;

  // ========================================================================
  // Registers and decoded fields.
  tpw_byte_t timer_control; // Bit 7 is never stored.
  tpw_byte_t timer_count_value; // The counter itself.
  tpw_byte_t compare_value; // Value software wrote.
  tpw_byte_t compare_active; // Buffered copy the comparator uses.
  tpw_byte_t timer_interrupt_mask; // Enables in bits 7 and 6.
  logic compare_match_flag; // Sticky compare event.
  logic overflow_flag; // Sticky overflow event.
  logic count_down; // Phase-correct slope direction.
  logic match_blocked; // Set by a counter write until next tick.
  logic wave_state; // Waveform generator output.
  tpw_wave_e wave_mode_field; // Counting sequence.
  tpw_outmode_e output_mode_field; // Output action.
  tpw_clksel_e clock_select_field; // Timer clock source.
  logic timer_count_enable; // One-cycle count enable.

  assign wave_mode_field = tpw_wave_e'({timer_control[`TPW_CTL_WAVE_HI],
                                        timer_control[`TPW_CTL_WAVE_LO]});
  assign output_mode_field = tpw_outmode_e'(
    timer_control[`TPW_CTL_OUT_HI:`TPW_CTL_OUT_LO]);
  assign clock_select_field = tpw_clksel_e'(
    timer_control[`TPW_CTL_CS_HI:`TPW_CTL_CS_LO]);

  // ========================================================================
  // Timer clock source; a count enable, never a clock of its own.
  tpw_prescaler #(.WIDTH(PRESCALE_BITS)) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .clock_select(clock_select_field),
    .external_count_pin(external_count_pin),
    .timer_count_enable(timer_count_enable)
  );

  // ========================================================================
  // Register bus write side. Address and data are held until both are in.
  logic aw_held; // Write address captured.
  logic w_held; // Write data captured.
  tpw_addr_t wr_addr; // Captured write address.
  tpw_byte_t wr_byte; // Captured low byte of write data.
  logic wr_lane0; // Low byte lane enabled.
  logic wr_go; // Both halves present: perform the write.

  assign awready = !aw_held && !bvalid;
  assign wready = !w_held && !bvalid;
  assign wr_go = aw_held && w_held && !bvalid;

  // Capture each half as it is taken, in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_byte <= '0;
      wr_lane0 <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_addr <= awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_byte <= wdata[7:0];
        wr_lane0 <= wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // Which register this write touches; unmapped addresses answer SLVERR.
  logic wr_ctl, wr_cnt, wr_cmp, wr_msk, wr_flg, wr_mapped;
  assign wr_ctl = wr_go && wr_lane0 && wr_addr == `TPW_OFS_CONTROL;
  assign wr_cnt = wr_go && wr_lane0 && wr_addr == `TPW_OFS_COUNT;
  assign wr_cmp = wr_go && wr_lane0 && wr_addr == `TPW_OFS_COMPARE;
  assign wr_msk = wr_go && wr_lane0 && wr_addr == `TPW_OFS_MASK;
  assign wr_flg = wr_go && wr_lane0 && wr_addr == `TPW_OFS_FLAGS;
  assign wr_mapped = wr_addr == `TPW_OFS_CONTROL ||
    wr_addr == `TPW_OFS_COUNT || wr_addr == `TPW_OFS_COMPARE ||
    wr_addr == `TPW_OFS_MASK || wr_addr == `TPW_OFS_FLAGS;

  // Write response; stands until the master takes it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `TPW_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp <= wr_mapped ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Software-owned registers. The force bit is a strobe and is not kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_control <= `TPW_RST_BYTE;
      compare_value <= `TPW_RST_BYTE;
      timer_interrupt_mask <= `TPW_RST_BYTE;
    end else begin
      if (wr_ctl) begin
        timer_control <= {1'b0, wr_byte[6:0]};
      end
      if (wr_cmp) begin
        compare_value <= wr_byte;
      end
      if (wr_msk) begin
        timer_interrupt_mask <= wr_byte;
      end
    end
  end

  // ========================================================================
  // Register bus read side; data stands until rready.
  tpw_word_t next_rdata; // Read data for the address offered.
  logic rd_mapped; // Offered read address is a register.

  always_comb begin
    next_rdata = '0;
    rd_mapped = 1'b1;
    case (araddr)
      `TPW_OFS_CONTROL: next_rdata[7:0] = timer_control;
      `TPW_OFS_COUNT: next_rdata[7:0] = timer_count_value;
      `TPW_OFS_COMPARE: next_rdata[7:0] = compare_value;
      `TPW_OFS_MASK: next_rdata[7:0] = timer_interrupt_mask;
      `TPW_OFS_FLAGS: begin
        next_rdata[`TPW_FLG_COMPARE] = compare_match_flag;
        next_rdata[`TPW_FLG_OVERFLOW] = overflow_flag;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  assign arready = !rvalid;

  // Read answer one edge after the address is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `TPW_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= next_rdata;
      rresp <= rd_mapped ? `TPW_RESP_OKAY : `TPW_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // ========================================================================
  // Compare and overflow events.
  logic is_pwm; // Either PWM mode is selected.
  logic at_max; // Counter sits at 0xff.
  logic match_now; // Real compare match on this tick.
  logic overflow_now; // Overflow event on this tick.
  logic top_ignore; // Compare at TOP with upper output bit set.
  logic force_now; // Force strobe written in a non-PWM mode.

  assign is_pwm = timer_control[`TPW_CTL_WAVE_LO];
  assign at_max = timer_count_value == `TPW_TOP_MAX;
  assign match_now = timer_count_enable && !match_blocked &&
    timer_count_value == compare_active;
  assign overflow_now = timer_count_enable &&
    ((wave_mode_field == TPW_WAVE_PHASE) ?
     (count_down && timer_count_value == `TPW_BOTTOM) : at_max);
  assign top_ignore = compare_active == `TPW_TOP_MAX &&
    timer_control[`TPW_CTL_OUT_HI];
  // In a PWM-mode write the force bit is simply ignored.
  assign force_now = wr_ctl && wr_byte[`TPW_CTL_FORCE] &&
    !wr_byte[`TPW_CTL_WAVE_LO];

  // ========================================================================
  // Counter, slope direction and match blocking.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_value <= `TPW_RST_BYTE;
      count_down <= 1'b0;
      match_blocked <= 1'b0;
    end else if (wr_cnt) begin
      timer_count_value <= wr_byte;
      match_blocked <= 1'b1;
    end else begin
      if (timer_count_enable) begin
        match_blocked <= 1'b0;
      end
      if (wave_mode_field != TPW_WAVE_PHASE) begin
        count_down <= 1'b0;
      end
      if (timer_count_enable) begin
        case (wave_mode_field)
          TPW_WAVE_CTC: begin
            // Only a real match clears; a forced one does not.
            timer_count_value <= match_now ? `TPW_BOTTOM :
              timer_count_value + `TPW_ONE;
          end
          TPW_WAVE_PHASE: begin
            // Turn round at both ends so each end lasts one tick.
            if (!count_down && at_max) begin
              count_down <= 1'b1;
              timer_count_value <= timer_count_value - `TPW_ONE;
            end else if (count_down &&
                         timer_count_value == `TPW_BOTTOM) begin
              count_down <= 1'b0;
              timer_count_value <= timer_count_value + `TPW_ONE;
            end else if (count_down) begin
              timer_count_value <= timer_count_value - `TPW_ONE;
            end else begin
              timer_count_value <= timer_count_value + `TPW_ONE;
            end
          end
          default: timer_count_value <= timer_count_value + `TPW_ONE;
        endcase
      end
    end
  end

  // Compare buffer: immediate, or reloaded at TOP in either PWM mode.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_active <= `TPW_RST_BYTE;
    end else if (!is_pwm || (timer_count_enable && at_max &&
                 (wave_mode_field == TPW_WAVE_FAST || !count_down))) begin
      compare_active <= compare_value;
    end
  end

  // ========================================================================
  // Waveform generator.
  logic next_wave; // Output after this cycle's events.

  always_comb begin
    next_wave = wave_state;
    case (wave_mode_field)
      TPW_WAVE_FAST: begin
        if (timer_count_enable && at_max) begin
          // BOTTOM action still happens when the match is ignored.
          if (output_mode_field == TPW_OUT_CLEAR) next_wave = 1'b1;
          if (output_mode_field == TPW_OUT_SET) next_wave = 1'b0;
        end else if (match_now && !top_ignore) begin
          if (output_mode_field == TPW_OUT_CLEAR) next_wave = 1'b0;
          if (output_mode_field == TPW_OUT_SET) next_wave = 1'b1;
        end
      end
      TPW_WAVE_PHASE: begin
        if (top_ignore) begin
          // Compare at TOP: the level is taken at TOP, not on a match.
          if (timer_count_enable && at_max && !count_down) begin
            next_wave = (output_mode_field == TPW_OUT_CLEAR);
          end
        end else if (match_now) begin
          if (output_mode_field == TPW_OUT_CLEAR) begin
            next_wave = count_down;
          end else if (output_mode_field == TPW_OUT_SET) begin
            next_wave = !count_down;
          end
        end
      end
      default: begin
        if (match_now || force_now) begin
          case (force_now ? tpw_outmode_e'(wr_byte[5:4]) :
                output_mode_field)
            TPW_OUT_TOGGLE: next_wave = !wave_state;
            TPW_OUT_CLEAR: next_wave = 1'b0;
            TPW_OUT_SET: next_wave = 1'b1;
            default: next_wave = wave_state;
          endcase
        end
      end
    endcase
  end

  // Waveform state and pin drive; the pin follows one edge later.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_state <= 1'b0;
      wave_pin_out <= 1'b0;
      wave_pin_oe <= 1'b0;
    end else begin
      wave_state <= next_wave;
      wave_pin_out <= (output_mode_field != TPW_OUT_OFF) ?
        wave_state : port_out_value;
      wave_pin_oe <= port_dir;
    end
  end

  // ========================================================================
  // Flags: the hardware set wins over an acknowledge or a write of one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_match_flag <= 1'b0;
      overflow_flag <= 1'b0;
    end else begin
      if (match_now) begin
        compare_match_flag <= 1'b1;
      end else if (compare_irq_ack ||
                   (wr_flg && wr_byte[`TPW_FLG_COMPARE])) begin
        compare_match_flag <= 1'b0;
      end
      if (overflow_now) begin
        overflow_flag <= 1'b1;
      end else if (overflow_irq_ack ||
                   (wr_flg && wr_byte[`TPW_FLG_OVERFLOW])) begin
        overflow_flag <= 1'b0;
      end
    end
  end

  assign compare_irq_req = compare_match_flag && global_irq_enable &&
    timer_interrupt_mask[`TPW_MSK_COMPARE];
  assign overflow_irq_req = overflow_flag && global_irq_enable &&
    timer_interrupt_mask[`TPW_MSK_OVERFLOW];

  // ========================================================================
  // Checks.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_count_written;
    wr_cnt;
  endsequence

  sequence s_fast_wrap;
    wave_mode_field == TPW_WAVE_FAST && timer_count_enable && at_max &&
      output_mode_field == TPW_OUT_CLEAR;
  endsequence

  property p_force_quiet;
    force_now && !match_now && !compare_match_flag |=> !compare_match_flag;
  endproperty
  a_force_quiet: assert property (p_force_quiet)
    else $error("force strobe set the compare flag");

  property p_force_reads_zero;
    arvalid && arready && araddr == `TPW_OFS_CONTROL |=> !rdata[7];
  endproperty
  a_force_reads_zero: assert property (p_force_reads_zero)
    else $error("force bit read back as one");

  property p_ctc_clear;
    wave_mode_field == TPW_WAVE_CTC && match_now && !wr_cnt
      |=> timer_count_value == `TPW_BOTTOM;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear)
    else $error("counter not cleared on compare match");

  property p_overflow_flag;
    overflow_now |=> overflow_flag;
  endproperty
  a_overflow_flag: assert property (p_overflow_flag)
    else $error("overflow flag missed");

  property p_match_flag;
    match_now |=> compare_match_flag ##1 1;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("compare flag missed");

  property p_write_blocks;
    s_count_written |=> !match_now;
  endproperty
  a_write_blocks: assert property (p_write_blocks)
    else $error("match not blocked after counter write");

  property p_stopped;
    clock_select_field == TPW_CS_STOP && !wr_cnt |=>
      $stable(timer_count_value);
  endproperty
  a_stopped: assert property (p_stopped)
    else $error("counter moved while stopped");

  property p_fast_bottom;
    s_fast_wrap |=> wave_state ##1
      (wave_pin_out || $past(output_mode_field) == TPW_OUT_OFF);
  endproperty
  a_fast_bottom: assert property (p_fast_bottom)
    else $error("fast mode output not set at bottom");

  property p_override;
    output_mode_field != TPW_OUT_OFF && $stable(timer_control)
      |=> wave_pin_out == $past(wave_state);
  endproperty
  a_override: assert property (p_override)
    else $error("pin not driven from waveform");

  property p_compare_req;
    compare_match_flag && global_irq_enable &&
      timer_interrupt_mask[`TPW_MSK_COMPARE] |-> compare_irq_req;
  endproperty
  a_compare_req: assert property (p_compare_req)
    else $error("compare request missing");

endmodule : tpw_timer

// >>> tpw_consts.svh
`ifndef TPW_CONSTS_SVH
`define TPW_CONSTS_SVH

// ==========================================================================
// Register byte offsets on the register bus.
`define TPW_OFS_CONTROL 8'h00
`define TPW_OFS_COUNT 8'h04
`define TPW_OFS_COMPARE 8'h08
`define TPW_OFS_MASK 8'h0c
`define TPW_OFS_FLAGS 8'h10

// ==========================================================================
// Field positions in the control, mask and flag registers.
`define TPW_CTL_FORCE 7
`define TPW_CTL_WAVE_HI 6
`define TPW_CTL_OUT_HI 5
`define TPW_CTL_OUT_LO 4
`define TPW_CTL_WAVE_LO 3
`define TPW_CTL_CS_HI 2
`define TPW_CTL_CS_LO 0
`define TPW_MSK_COMPARE 7
`define TPW_MSK_OVERFLOW 6
`define TPW_FLG_COMPARE 7
`define TPW_FLG_OVERFLOW 6

// ==========================================================================
// Reset values and counter end points.
`define TPW_RST_BYTE 8'h00
`define TPW_TOP_MAX 8'hff
`define TPW_BOTTOM 8'h00
`define TPW_ONE 8'h01

// ==========================================================================
// Prescaler tap masks: a tap fires when all its low bits are ones.
`define TPW_DIV8_MASK 10'h007
`define TPW_DIV64_MASK 10'h03f
`define TPW_DIV256_MASK 10'h0ff
`define TPW_DIV1024_MASK 10'h3ff

// ==========================================================================
// Bus response codes.
`define TPW_RESP_OKAY 2'b00
`define TPW_RESP_SLVERR 2'b10

`endif

// >>> tpw_pkg.sv
package tpw_pkg;

  // ========================================================================
  // Common data types.
  typedef logic [7:0] tpw_byte_t;
  typedef logic [31:0] tpw_word_t;
  typedef logic [7:0] tpw_addr_t;

  // Counting sequence, in the order of the two-bit wave mode field.
  typedef enum logic [1:0] {
    TPW_WAVE_NORMAL,
    TPW_WAVE_PHASE,
    TPW_WAVE_CTC,
    TPW_WAVE_FAST
  } tpw_wave_e;

  // Output mode field values.
  typedef enum logic [1:0] {
    TPW_OUT_OFF,
    TPW_OUT_TOGGLE,
    TPW_OUT_CLEAR,
    TPW_OUT_SET
  } tpw_outmode_e;

  // Clock select field values.
  typedef enum logic [2:0] {
    TPW_CS_STOP,
    TPW_CS_DIV1,
    TPW_CS_DIV8,
    TPW_CS_DIV64,
    TPW_CS_DIV256,
    TPW_CS_DIV1024,
    TPW_CS_EXT_FALL,
    TPW_CS_EXT_RISE
  } tpw_clksel_e;

endpackage : tpw_pkg

// >>> tpw_prescaler.sv
`timescale 1ns/1ns
`include "tpw_consts.svh"

module tpw_prescaler #(
  parameter int WIDTH = 10
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire tpw_pkg::tpw_clksel_e clock_select,
  input wire logic external_count_pin,
  output logic timer_count_enable
);
  import tpw_pkg::*;

  // Free running divider; all taps share it so no tap restarts on select.
  logic [WIDTH-1:0] pre_count;
  // Last sampled level of the external pin, for edge detection.
  logic ext_prev;

  // ========================================================================
  // Divider and pin history.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_count <= '0;
      ext_prev <= 1'b0;
    end else begin
      pre_count <= pre_count + WIDTH'(1);
      ext_prev <= external_count_pin;
    end
  end

  // The pin is read even when the port drives it, so software can count.
  always_comb begin
    case (clock_select)
      TPW_CS_STOP: timer_count_enable = 1'b0;
      TPW_CS_DIV1: timer_count_enable = 1'b1;
      TPW_CS_DIV8: timer_count_enable =
        (pre_count & WIDTH'(`TPW_DIV8_MASK)) == WIDTH'(`TPW_DIV8_MASK);
      TPW_CS_DIV64: timer_count_enable =
        (pre_count & WIDTH'(`TPW_DIV64_MASK)) == WIDTH'(`TPW_DIV64_MASK);
      TPW_CS_DIV256: timer_count_enable =
        (pre_count & WIDTH'(`TPW_DIV256_MASK)) == WIDTH'(`TPW_DIV256_MASK);
      TPW_CS_DIV1024: timer_count_enable =
        (pre_count & WIDTH'(`TPW_DIV1024_MASK)) == WIDTH'(`TPW_DIV1024_MASK);
      TPW_CS_EXT_FALL: timer_count_enable = ext_prev && !external_count_pin;
      TPW_CS_EXT_RISE: timer_count_enable = !ext_prev && external_count_pin;
      default: timer_count_enable = 1'b0;
    endcase
  end

endmodule : tpw_prescaler

// >>> tpw_pin_partner.sv
`timescale 1ns/1ns
// ==========================================================================
// Pin-side model: the counting pin source and the pad behind the wave pin.
module tpw_pin_partner (
  input wire logic aclk,
  input wire logic wave_pin_out,
  input wire logic wave_pin_oe,
  output logic external_count_pin,
  output logic pin_level
);
  // The pad has a pull-up, so a released pin reads high, never stale.
  assign pin_level = wave_pin_oe ? wave_pin_out : 1'b1;
  // The counting pin idles low until software asks for edges.
  initial begin
    external_count_pin = 1'b0;
  end
  // Each pulse is one rise and one fall, held long enough to be seen.
  task pulse(input int n);
    repeat (n) begin
      repeat (3) @(posedge aclk);
      external_count_pin <= 1'b1;
      repeat (3) @(posedge aclk);
      external_count_pin <= 1'b0;
    end
  endtask : pulse
endmodule : tpw_pin_partner

// >>> eight_bit_timer_pwm_unit_tb.sv
`timescale 1ns/1ns
`include "tpw_consts.svh"
module eight_bit_timer_pwm_unit_tb;
  import tpw_pkg::*;
  // ========================================================================
  // Signals; names follow the design ports so they connect by name.
  typedef struct {tpw_byte_t a; tpw_byte_t w; int e;} tpw_row_s;
  logic aclk = 0;
  logic aresetn = 0;
  tpw_addr_t awaddr = 0;
  tpw_addr_t araddr = 0;
  tpw_word_t wdata = 0;
  tpw_word_t rdata;
  tpw_word_t v;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, pin_level;
  logic [1:0] bresp, rresp, rsp;
  logic external_count_pin, port_out_value = 0, port_dir = 0;
  logic global_irq_enable = 0, compare_irq_ack = 0, overflow_irq_ack = 0;
  logic wave_pin_out, wave_pin_oe, compare_irq_req, overflow_irq_req;
  int n_fail = 0, checks_done = 0, hi;
  int divs[4] = '{8, 64, 256, 1024};
  // Register rows: offset, written byte, expected read-back.
  tpw_row_s rows[5] = '{'{8'h00, 8'h80, 0}, '{8'h04, 8'h33, 'h33},
    '{8'h08, 8'h5a, 'h5a}, '{8'h0c, 8'hc0, 'hc0}, '{8'h00, 8'h48, 'h48}};
  // Wave rows: control, compare, high cycles seen in 512.
  tpw_row_s pw[5] = '{'{8'h69, 8'h40, 130}, '{8'h79, 8'h40, 382},
    '{8'h39, 8'h40, 383}, '{8'h69, 8'hff, 512}, '{8'h29, 8'hff, 512}};
  always #20 aclk = ~aclk;
  // Prot and strobes are tied: the design ignores prot and reads only wstrb[0].
  tpw_timer tpw_timer_i (.aclk, .aresetn, .awaddr, .awprot(3'b000),
    .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arprot(3'b000), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .external_count_pin, .port_out_value,
    .port_dir, .global_irq_enable, .compare_irq_ack, .overflow_irq_ack,
    .wave_pin_out, .wave_pin_oe, .compare_irq_req, .overflow_irq_req);
  tpw_pin_partner tpw_pin_partner_i (.aclk, .wave_pin_out, .wave_pin_oe,
    .external_count_pin, .pin_level);
  // ========================================================================
  // Checking and bus tasks.
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // Handshakes are judged at the falling edge, where inputs are settled.
  task wr(input tpw_addr_t a, input tpw_word_t d);
    bit aw, w, b;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    b = 0;
    for (int i = 0; i < 50 && !b; i++) begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid;
      rsp = bresp;
      @(posedge aclk);
      if (aw) awvalid <= 0;
      if (w) wvalid <= 0;
    end
    bready <= 0;
    @(posedge aclk);
    if (!b) n_fail++;
  endtask : wr
  task rd(input tpw_addr_t a);
    bit ar, b;
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    b = 0;
    for (int i = 0; i < 50 && !b; i++) begin
      @(negedge aclk);
      ar = arvalid && arready;
      b = rvalid;
      v = rdata;
      rsp = rresp;
      @(posedge aclk);
      if (ar) arvalid <= 0;
    end
    rready <= 0;
    @(posedge aclk);
    if (!b) n_fail++;
  endtask : rd
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize
  // A hang past three times the expected run length is counted as a mismatch.
  initial begin
    repeat (30000) @(posedge aclk);
    n_fail++;
    summarize();
  end
  // ========================================================================
  // Main sequence.
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      chk(v, 0);
      chk(32'(rsp),
        i < 5 ? 32'(`TPW_RESP_OKAY) : 32'(`TPW_RESP_SLVERR));
    end
    $display("test reset done");
    foreach (rows[i]) begin
      wr(rows[i].a, 32'(rows[i].w));
      chk(32'(rsp), 32'(`TPW_RESP_OKAY));
      rd(rows[i].a);
      chk(v, 32'(rows[i].e));
    end
    $display("test registers done");
    // Mode off passes the port value; toggle mode, then forced to toggle and to clear.
    port_dir <= 1;
    port_out_value <= 1;
    wr(`TPW_OFS_CONTROL, 32'h0);
    chk(pin_level, 1);
    wr(`TPW_OFS_CONTROL, 32'h10);
    chk(pin_level, 0);
    wr(`TPW_OFS_CONTROL, 32'h90);
    chk(pin_level, 1);
    wr(`TPW_OFS_CONTROL, 32'ha0);
    chk(pin_level, 0);
    rd(`TPW_OFS_FLAGS);
    chk(v, 0);
    $display("test force done");
    global_irq_enable <= 1;
    wr(`TPW_OFS_MASK, 32'h40);
    wr(`TPW_OFS_COUNT, 32'hfd);
    wr(`TPW_OFS_CONTROL, 32'h01);
    for (int i = 0; i < 40 && overflow_irq_req !== 1'b1; i++) @(negedge aclk);
    chk(overflow_irq_req, 1);
    @(posedge aclk);
    wr(`TPW_OFS_CONTROL, 32'h0);
    overflow_irq_ack <= 1;
    @(posedge aclk);
    overflow_irq_ack <= 0;
    @(negedge aclk);
    chk(overflow_irq_req, 0);
    @(posedge aclk);
    $display("test overflow done");
    wr(`TPW_OFS_MASK, 32'hc0);
    wr(`TPW_OFS_COMPARE, 32'h3);
    wr(`TPW_OFS_COUNT, 32'h0);
    wr(`TPW_OFS_CONTROL, 32'h41);
    repeat (3) begin
      rd(`TPW_OFS_COUNT);
      chk(32'(v <= 3), 1);
    end
    wr(`TPW_OFS_CONTROL, 32'h0);
    chk(compare_irq_req, 1);
    wr(`TPW_OFS_FLAGS, 32'h80);
    rd(`TPW_OFS_FLAGS);
    chk(v, 0);
    $display("test clear on compare done");
    // Prescaled taps over 1024 cycles, then pin edges while pin drives.
    for (int cs = 2; cs < 8; cs++) begin
      wr(`TPW_OFS_COUNT, 32'h0);
      wr(`TPW_OFS_CONTROL, 32'(cs));
      if (cs > 5) begin
        tpw_pin_partner_i.pulse(5);
        repeat (4) @(posedge aclk);
      end
      else repeat (1024) @(posedge aclk);
      wr(`TPW_OFS_CONTROL, 32'h0);
      rd(`TPW_OFS_COUNT);
      hi = cs > 5 ? 5 : 1024 / divs[cs - 2];
      chk(32'(v - hi <= 32'(cs < 6)), 1);
    end
    $display("test clock select done");
    // Waveform duty in the two PWM modes, ending with compare at TOP.
    foreach (pw[i]) begin
      wr(`TPW_OFS_CONTROL, 32'h0);
      wr(`TPW_OFS_COMPARE, 32'(pw[i].w));
      wr(`TPW_OFS_COUNT, 32'h0);
      wr(`TPW_OFS_CONTROL, 32'(pw[i].a));
      repeat (600) @(posedge aclk);
      hi = 0;
      repeat (512) begin
        @(negedge aclk);
        hi += int'(pin_level === 1'b1);
      end
      @(posedge aclk);
      chk(32'(hi >= pw[i].e - 4 && hi <= pw[i].e + 4), 1);
    end
    $display("test waveform done");
    summarize();
  end
endmodule : eight_bit_timer_pwm_unit_tb
